// file: spe_map.svh
// spe_map.svh: opcodes, status layout, guard codes and timing
// assumes: included by bare name from the package only; the design files use its macros without including it
`ifndef SPE_MAP_SVH
`define SPE_MAP_SVH

// opcode: upper nibble fixed, bit 3 carries the top address bit
`define SPE_OPC_HI      4'h0
`define SPE_OPC_ARM     3'h6
`define SPE_OPC_DISARM  3'h4
`define SPE_OPC_FETCH   3'h5
`define SPE_OPC_STORE   3'h1
`define SPE_OPC_READ    3'h3
`define SPE_OPC_WRITE   3'h2
`define SPE_OPC_TOP     3

// status word bit positions and reset value
`define SPE_ST_BUSY     0
`define SPE_ST_ARM      1
`define SPE_ST_GLO      2
`define SPE_ST_GHI      3
`define SPE_ST_RST      8'h00
`define SPE_GUARD_RST   2'h0

// guard size codes
`define SPE_GUARD_NONE  2'h0
`define SPE_GUARD_QTR   2'h1
`define SPE_GUARD_HALF  2'h2

// geometry
`define SPE_ADDR_BITS   9
`define SPE_PAGE_BITS   5
`define SPE_BIT_LAST    3'h7
`define SPE_BIT_FIRST   3'h0

// timing: write time in ns, clock period in ns
`define SPE_TW_NS       5000000
`define SPE_CLK_NS      10

`endif

// file: spe_pkg.sv
// spe_pkg: shared types of the serial eeprom command logic
// assumes: spe_map.svh holds the numbers
package spe_pkg;
  `include "spe_map.svh"

  typedef enum logic [2:0] {
    s_opc, s_addr, s_rdata, s_wdata, s_sdata, s_sdone, s_stat, s_ignore
  } spe_state_e;

  typedef enum logic [1:0] {
    p_none, p_status, p_array
  } spe_prog_e;
endpackage : spe_pkg

// file: spe_sync.sv
// spe_sync: two flip-flop synchroniser for a group of pin inputs
// assumes: inputs are asynchronous to clk
`timescale 1ns/1ns
module spe_sync #(
  parameter int           W   = 5,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST;
      dout <= RST;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : spe_sync

// file: spe_mem.sv
// spe_mem: byte array with a page buffer committed in one step
// assumes: commit only while no loads are under way
`timescale 1ns/1ns
module spe_mem #(
  parameter int AW = 9,
  parameter int PB = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [AW-1:0] rd_addr,
  output      logic [7:0]    rd_data,
  input  wire logic          ld_clr,
  input  wire logic          ld_en,
  input  wire logic [PB-1:0] ld_idx,
  input  wire logic [7:0]    ld_data,
  input  wire logic          commit,
  input  wire logic [AW-PB-1:0] page
);
  localparam int NB = 1 << PB;

  logic [7:0]    mem   [0:(1<<AW)-1];
  logic [7:0]    pbuf  [0:NB-1];
  logic [NB-1:0] mask;

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  // page buffer bytes, later loads overwrite earlier ones
  always_ff @(posedge clk) begin
    if (ld_en) begin
      pbuf[ld_idx] <= ld_data;
    end
  end

  // which buffer bytes hold new data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (ld_clr) begin
      mask <= '0;
    end else if (ld_en) begin
      mask[ld_idx] <= 1'b1;
    end
  end

  // all loaded bytes land together at the end of programming
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < NB; i++) begin
        if (mask[i]) begin
          mem[{page, PB'(i)}] <= pbuf[i];
        end
      end
    end
  end
endmodule : spe_mem

// file: spe_eeprom.sv
// spe_eeprom: instruction logic of a small serial eeprom
// assumes: serial pins arrive asynchronous to clk and are much slower
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// How it works
// - serial output changes only on falling serial clock edges
// - input bits sampled on rising serial clock edges
// - deselected means output floated; standby unless programming
// - after power-up nothing counts until select falls once
// - hold floats output and ignores clock and input
// - write-protect low refuses store and write; running cycle finishes
// - unknown opcode makes the rest of the frame ignored
// - opcode byte msb first; arm, disarm, status fetch codes
// - store, read, write codes; bit 3 is top address bit
// - only arm sets the latch, on select rising
// - latch cleared at reset, disarm, cycle end, protect low
// - status fetch always honoured, repeats with fresh values
// - busy reads 1 during programming; latch clear refuses writes
// - store changes only guard bits; bits 6..4 read zero
// - store must end right after eighth data bit, else dropped
// - store starts timed cycle on select rise; busy; latch clears
// - guard bits keep old values until store cycle ends
// - read loads address, streams bytes, increments with wrap
// - read ends at select rise; refused while programming
// - write needs a data byte; ends at byte boundary, timed cycle
// - write data wraps inside the 32 byte page
// - write refused: latch clear, busy, guarded page, protect low
// - guard pair selects none, upper quarter, upper half, all
// - hold starts and ends only while clock low; deselect resets
module spe_eeprom
  import spe_pkg::*;
#(
  parameter int AW           = `SPE_ADDR_BITS,
  parameter int WRITE_CYCLES = `SPE_TW_NS / `SPE_CLK_NS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ser_clk,
  input  wire logic sel_n,
  input  wire logic ser_in,
  input  wire logic wprot_n,
  input  wire logic hold_n,
  output      logic ser_out,
  output      logic ser_out_oe,
  output      logic standby
);
  localparam int PB = `SPE_PAGE_BITS;
  localparam int TW = $clog2(WRITE_CYCLES + 1);

  logic             sck_s, sel_n_s, sin_s, wp_n_s, hold_n_s;
  logic             sck_d, sel_d, powered, hold_act;
  logic             sck_rise, sck_fall, sel_rise, live;
  logic             rise, fall, byte_done, got_byte, ok_wr;
  spe_state_e       state, next_state;
  spe_prog_e        kind;
  logic [2:0]       bit_cnt, cmd;
  logic [7:0]       sh_in, byte_in, out_sh, status_word, rd_data;
  logic [8:0]       full_addr;
  logic [AW-1:0]    addr;
  logic             top_address_bit, busy_flag, arm_latch, prog_done;
  logic [1:0]       guard, guard_new;
  logic [TW-1:0]    timer;
  logic             arm_ev, disarm_ev, start_stat, start_arr, act_rise;

  // write-locked region for a guard code
  function automatic logic guarded(logic [1:0] g, logic [AW-1:0] a);
    case (g)
      `SPE_GUARD_NONE: guarded = 1'b0;
      `SPE_GUARD_QTR:  guarded = &a[AW-1:AW-2];
      `SPE_GUARD_HALF: guarded = a[AW-1];
      default:         guarded = 1'b1;
    endcase
  endfunction : guarded

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finding
  spe_sync #(
    .W   (5),
    .RST (5'h1f)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({hold_n, wprot_n, ser_in, sel_n, ser_clk}),
    .dout  ({hold_n_s, wp_n_s, sin_s, sel_n_s, sck_s})
  );

  // delayed copies for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b1;
      sel_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      sel_d <= sel_n_s;
    end
  end

  // first select fall after power-up opens the device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powered <= 1'b0;
    end else if (!sel_n_s && sel_d) begin
      powered <= 1'b1;
    end
  end

  // hold pause, entered only while the clock is low, left while it is low or on deselect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_act <= 1'b0;
    end else if (sel_n_s) begin
      hold_act <= 1'b0;
    end else if (!sck_s) begin
      hold_act <= ~hold_n_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_d;
  assign sck_fall  = ~sck_s & sck_d;
  assign sel_rise  = sel_n_s & ~sel_d;
  assign live      = powered & ~sel_n_s & ~hold_act;
  assign rise      = sck_rise & live;
  assign fall      = sck_fall & live;
  assign byte_in   = {sh_in[6:0], sin_s};
  assign byte_done = rise && (bit_cnt == `SPE_BIT_LAST);
  assign full_addr = {top_address_bit, byte_in};
  assign ok_wr     = arm_latch & ~busy_flag & wp_n_s;
  // deselect while holding resets without acting
  assign act_rise  = sel_rise & ~hold_act & powered;

  //////////////////////////////////////////////////////////////////////
  // instruction decode
  always_comb begin
    next_state = state;
    case (state)
      s_opc: begin
        if (byte_in[7:4] != `SPE_OPC_HI) begin
          next_state = s_ignore;
        end else begin
          case (byte_in[2:0])
            `SPE_OPC_ARM:    next_state = s_sdone;
            `SPE_OPC_DISARM: next_state = s_sdone;
            `SPE_OPC_FETCH:  next_state = s_stat;
            `SPE_OPC_STORE:  next_state = ok_wr ? s_sdata : s_ignore;
            `SPE_OPC_READ:   next_state = busy_flag ? s_ignore : s_addr;
            `SPE_OPC_WRITE:  next_state = ok_wr ? s_addr : s_ignore;
            default:         next_state = s_ignore;
          endcase
        end
      end
      s_addr: begin
        if (cmd == `SPE_OPC_READ) begin
          next_state = s_rdata;
        end else if (guarded(guard, full_addr[AW-1:0])) begin
          next_state = s_ignore;
        end else begin
          next_state = s_wdata;
        end
      end
      s_sdata: next_state = s_sdone;
      default: next_state = state;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // frame sequencer: bit counter, input shifter, state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= s_opc;
      bit_cnt  <= `SPE_BIT_FIRST;
      sh_in    <= 8'h00;
      cmd      <= 3'h0;
      top_address_bit <= 1'b0;
      got_byte <= 1'b0;
    end else if (sel_n_s) begin
      state    <= s_opc;
      bit_cnt  <= `SPE_BIT_FIRST;
      got_byte <= 1'b0;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      sh_in   <= byte_in;
      if (state == s_sdone && cmd == `SPE_OPC_STORE) begin
        state <= s_ignore;
      end else if (byte_done) begin
        state <= next_state;
        if (state == s_opc) begin
          cmd <= byte_in[2:0];
          top_address_bit <= byte_in[`SPE_OPC_TOP];
        end
        if (state == s_wdata) begin
          got_byte <= 1'b1;
        end
      end
    end
  end

  // address register: load, read increment, in-page write increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
    end else if (byte_done && state == s_addr) begin
      addr <= full_addr[AW-1:0];
    end else if (byte_done && state == s_rdata) begin
      addr <= addr + AW'(1);
    end else if (byte_done && state == s_wdata) begin
      addr[PB-1:0] <= addr[PB-1:0] + PB'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output shifter, moves only on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_out <= 1'b0;
      out_sh  <= 8'h00;
    end else if (fall && (state == s_stat || state == s_rdata)) begin
      if (bit_cnt == `SPE_BIT_FIRST) begin
        // fresh byte: current status or next array byte
        if (state == s_stat) begin
          ser_out <= status_word[7];
          out_sh  <= {status_word[6:0], 1'b0};
        end else begin
          ser_out <= rd_data[7];
          out_sh  <= {rd_data[6:0], 1'b0};
        end
      end else begin
        ser_out <= out_sh[7];
        out_sh  <= {out_sh[6:0], 1'b0};
      end
    end
  end

  // drive only when selected, not held, and sending
  assign ser_out_oe = ~sel_n_s & ~hold_act &
                      (state == s_stat || state == s_rdata);
  assign standby    = sel_n_s & ~busy_flag;

  //////////////////////////////////////////////////////////////////////
  // frame-end actions taken at select rise
  assign arm_ev     = act_rise && state == s_sdone &&
                      cmd == `SPE_OPC_ARM && wp_n_s;
  assign disarm_ev  = act_rise && state == s_sdone &&
                      cmd == `SPE_OPC_DISARM;
  assign start_stat = act_rise && state == s_sdone &&
                      cmd == `SPE_OPC_STORE && ok_wr;
  // mid-byte rise or no data byte abandons the write
  assign start_arr  = act_rise && state == s_wdata && got_byte &&
                      bit_cnt == `SPE_BIT_FIRST && ok_wr;
  assign prog_done  = busy_flag && timer == TW'(WRITE_CYCLES - 1);

  // self-timed programming cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_flag <= 1'b0;
      timer     <= '0;
      kind      <= p_none;
    end else if (start_stat || start_arr) begin
      busy_flag <= 1'b1;
      timer     <= '0;
      kind      <= start_stat ? p_status : p_array;
    end else if (prog_done) begin
      busy_flag <= 1'b0;
      kind      <= p_none;
    end else if (busy_flag) begin
      timer <= timer + TW'(1);
    end
  end

  // write arm latch; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_latch <= 1'b0;
    end else begin
      if (prog_done || !wp_n_s || disarm_ev) begin
        arm_latch <= 1'b0;
      end
      if (arm_ev) begin
        arm_latch <= 1'b1;
      end
    end
  end

  // guard bits: captured from store data, applied at cycle end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard     <= `SPE_GUARD_RST;
      guard_new <= `SPE_GUARD_RST;
    end else begin
      if (byte_done && state == s_sdata) begin
        guard_new <= byte_in[`SPE_ST_GHI:`SPE_ST_GLO];
      end
      if (prog_done && kind == p_status) begin
        guard <= guard_new;
      end
    end
  end

  // status word layout, unused bits zero
  always_comb begin
    status_word               = `SPE_ST_RST;
    status_word[`SPE_ST_BUSY] = busy_flag;
    status_word[`SPE_ST_ARM]  = arm_latch;
    status_word[`SPE_ST_GLO]  = guard[0];
    status_word[`SPE_ST_GHI]  = guard[1];
  end

  //////////////////////////////////////////////////////////////////////
  // array storage with page buffer
  spe_mem #(
    .AW (AW),
    .PB (PB)
  ) u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .rd_addr (addr),
    .rd_data (rd_data),
    .ld_clr  (byte_done && state == s_addr),
    .ld_en   (byte_done && state == s_wdata),
    .ld_idx  (addr[PB-1:0]),
    .ld_data (byte_in),
    .commit  (prog_done && kind == p_array),
    .page    (addr[AW-1:PB])
  );

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_out_on_fall;
    @(posedge clk) disable iff (!rst_n)
      !sck_fall |=> $stable(ser_out);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall)
    else $error("serial output moved without a falling clock");

  property p_float_desel;
    @(posedge clk) disable iff (!rst_n)
      sel_n_s || hold_act |-> !ser_out_oe;
  endproperty
  a_float_desel: assert property (p_float_desel)
    else $error("output driven while deselected or held");

  property p_ignore_sticks;
    @(posedge clk) disable iff (!rst_n)
      state == s_ignore && !sel_n_s |=> state == s_ignore;
  endproperty
  a_ignore_sticks: assert property (p_ignore_sticks)
    else $error("ignored frame resumed decoding");

  property p_protect_clears;
    @(posedge clk) disable iff (!rst_n)
      !wp_n_s |=> !arm_latch;
  endproperty
  a_protect_clears: assert property (p_protect_clears)
    else $error("latch survived write protect");

  property p_busy_runs;
    @(posedge clk) disable iff (!rst_n)
      start_stat || start_arr |=> busy_flag [*8];
  endproperty
  a_busy_runs: assert property (p_busy_runs)
    else $error("busy dropped early");

  property p_done_clears;
    @(posedge clk) disable iff (!rst_n)
      prog_done && !arm_ev |=> !busy_flag && !arm_latch;
  endproperty
  a_done_clears: assert property (p_done_clears)
    else $error("cycle end left busy or latch set");

  property p_guard_frozen;
    @(posedge clk) disable iff (!rst_n)
      !$past(prog_done) |-> $stable(guard);
  endproperty
  a_guard_frozen: assert property (p_guard_frozen)
    else $error("guard bits changed outside cycle end");

  property p_write_allowed;
    @(posedge clk) disable iff (!rst_n)
      start_arr |-> arm_latch && wp_n_s && !busy_flag &&
                    !guarded(guard, addr);
  endproperty
  a_write_allowed: assert property (p_write_allowed)
    else $error("write started while refused");

  property p_read_wrap;
    @(posedge clk) disable iff (!rst_n)
      byte_done && state == s_rdata && &addr |=> addr == '0;
  endproperty
  a_read_wrap: assert property (p_read_wrap)
    else $error("read address did not wrap");

  property p_page_wrap;
    @(posedge clk) disable iff (!rst_n)
      byte_done && state == s_wdata && &addr[PB-1:0]
        |=> addr[PB-1:0] == '0 && $stable(addr[AW-1:PB]);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("write address left its page");

  property p_status_zero;
    @(posedge clk) disable iff (!rst_n)
      status_word[7:4] == 4'h0;
  endproperty
  a_status_zero: assert property (p_status_zero)
    else $error("status high bits not zero");
endmodule : spe_eeprom

// file: spe_host.sv
// spe_host: serial host model for the eeprom pins, mode 0, clock idles low
// assumes: driven through its tasks; link clock period 125 ns
`timescale 1ns/1ns
module spe_host (
  output logic      ser_clk,
  output logic      sel_n,
  output logic      ser_in,
  output logic      hold_n,
  input  wire logic ser_out,
  input  wire logic ser_out_oe
);
  logic [7:0] rx_byte;
  logic       oe_seen;
  int         rx_cnt = 0;
  int         gap_ns = 0;

  // pins idle: deselected, clock low, not held
  initial begin
    ser_clk = 1'b0;
    sel_n   = 1'b1;
    ser_in  = 1'b0;
    hold_n  = 1'b1;
    oe_seen = 1'b0;
  end

  // note any output drive during the frame
  always @(posedge ser_out_oe) oe_seen = 1'b1;

  ////////////////////////////////////////////////////////////////////
  // frame start with a falling select
  task automatic open_frame();
    oe_seen = 1'b0;
    sel_n   = 1'b0;
    #125;
  endtask : open_frame

  // select rises after the last falling clock, input line then toggled
  task automatic close_frame();
    #63;
    sel_n  = 1'b1;
    ser_in = ~ser_in;
    #250;
  endtask : close_frame

  // shift n bits msb first, capture output at each rising clock
  task automatic bits(input logic [7:0] v, input int n);
    logic [7:0] r;
    logic       full;
    r    = 8'h00;
    full = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      ser_in = v[i];
      #62;
      ser_clk = 1'b1;
      // a released line reads as the inverse of the last driven bit
      r       = {r[6:0], ser_out_oe ? ser_out : ~ser_out};
      full    = full & ser_out_oe;
      #63;
      ser_clk = 1'b0;
    end
    if (n == 8 && full === 1'b1) begin
      rx_byte = r;
      rx_cnt++;
    end
    #(gap_ns);
  endtask : bits

  // hold pause with clock low at both ends; clock wiggles inside
  task automatic pause(output logic oe_mid);
    hold_n = 1'b0;
    #100;
    ser_clk = 1'b1;
    ser_in  = ~ser_in;
    #100;
    ser_clk = 1'b0;
    oe_mid  = ser_out_oe;
    #100;
    hold_n = 1'b1;
    #125;
  endtask : pause
endmodule : spe_host

// file: spe_eeprom_test.sv
// spe_eeprom_test: self-checking bench of the serial eeprom logic
// assumes: spe_host drives the serial pins; write time shortened
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module spe_eeprom_test;
  import spe_pkg::*;
  localparam int WCYC = 2000;
  localparam logic [7:0] OPS [4] = '{8'h06, 8'h04, 8'h0e, 8'h0c};
  localparam logic [7:0] STS [4] = '{8'h02, 8'h00, 8'h02, 8'h00};
  localparam logic [7:0] BAD [4] = '{8'h85, 8'h07, 8'h00, 8'h16};
  logic       clk;
  logic       rst_n;
  logic       wprot_n;
  logic       ser_clk;
  logic       sel_n;
  logic       ser_in;
  logic       hold_n;
  logic       ser_out;
  logic       ser_out_oe;
  logic       standby;
  logic       oe_mid;
  logic [7:0] e;
  logic [7:0] d [5];
  logic [7:0] exp_q [$];
  int         errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         seed;

  spe_eeprom #(.AW(9), .WRITE_CYCLES(WCYC)) uut (
    .clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .sel_n(sel_n),
    .ser_in(ser_in), .wprot_n(wprot_n), .hold_n(hold_n),
    .ser_out(ser_out), .ser_out_oe(ser_out_oe), .standby(standby));
  spe_host u_host (
    .ser_clk(ser_clk), .sel_n(sel_n), .ser_in(ser_in), .hold_n(hold_n),
    .ser_out(ser_out), .ser_out_oe(ser_out_oe));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end

  // compare each byte read back against the oldest note
  always @(u_host.rx_cnt) begin
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    `CHK("rx_byte", e, u_host.rx_byte)
  end

  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cmd(input logic [7:0] op);
    u_host.open_frame();
    u_host.bits(op, 8);
    u_host.close_frame();
  endtask : cmd

  // status fetched twice in one frame
  task automatic fetch(input logic [7:0] st);
    exp_q.push_back(st);
    exp_q.push_back(st);
    u_host.open_frame();
    u_host.bits(8'h05, 8);
    u_host.bits(8'h00, 8);
    u_host.bits(8'h00, 8);
    u_host.close_frame();
  endtask : fetch

  task automatic rd(input logic [8:0] a, input int n);
    u_host.open_frame();
    u_host.bits({4'h0, a[8], 3'h3}, 8);
    u_host.bits(a[7:0], 8);
    repeat (n) u_host.bits(8'h00, 8);
    u_host.close_frame();
  endtask : rd

  task automatic wr(input logic [8:0] a, input int k, input int n);
    u_host.open_frame();
    u_host.bits({4'h0, a[8], 3'h2}, 8);
    u_host.bits(a[7:0], 8);
    for (int i = k; i < k + n; i++) u_host.bits(d[i], 8);
    u_host.close_frame();
  endtask : wr

  task automatic store(input logic [7:0] v);
    cmd(8'h06);
    u_host.open_frame();
    u_host.bits(8'h01, 8);
    u_host.bits(v, 8);
    u_host.close_frame();
  endtask : store

  task automatic settle();
    repeat (WCYC + 20) @(negedge clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed    = 54937;
    rst_n   = 1'b0;
    wprot_n = 1'b1;
    for (int i = 0; i < 5; i++) d[i] = 8'($random(seed));
    repeat (4) @(negedge clk);
    `CHK("oe_reset", 1'b0, ser_out_oe)
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("standby", 1'b1, standby)
    fetch(8'h00);
    foreach (OPS[i]) begin
      cmd(OPS[i]);
      fetch(STS[i]);
    end
    foreach (BAD[i]) begin
      u_host.open_frame();
      u_host.bits(BAD[i], 8);
      u_host.bits(8'h00, 8);
      u_host.close_frame();
      `CHK("oe_bad_op", 1'b0, u_host.oe_seen)
    end
    wr(9'h1fe, 0, 1);
    fetch(8'h00);
    // page write wrapping in its page, status and read while busy
    cmd(8'h06);
    wr(9'h1fe, 0, 3);
    @(negedge clk);
    `CHK("standby_busy", 1'b0, standby)
    fetch(8'h03);
    rd(9'h000, 1);
    `CHK("oe_rd_busy", 1'b0, u_host.oe_seen)
    settle();
    `CHK("standby_idle", 1'b1, standby)
    fetch(8'h00);
    cmd(8'h06);
    wr(9'h000, 3, 1);
    settle();
    exp_q.push_back(d[0]);
    exp_q.push_back(d[1]);
    exp_q.push_back(d[3]);
    rd(9'h1fe, 3);
    exp_q.push_back(d[2]);
    rd(9'h1e0, 1);
    // status store and guarded regions
    store(8'hff);
    fetch(8'h03);
    settle();
    fetch(8'h0c);
    cmd(8'h06);
    wr(9'h000, 4, 1);
    fetch(8'h0e);
    exp_q.push_back(d[3]);
    rd(9'h000, 1);
    store(8'h04);
    settle();
    fetch(8'h04);
    cmd(8'h06);
    wr(9'h180, 4, 1);
    fetch(8'h06);
    wr(9'h17f, 4, 1);
    settle();
    exp_q.push_back(d[4]);
    rd(9'h17f, 1);
    store(8'h00);
    settle();
    // write protect drops the latch and refuses; running cycle ends
    cmd(8'h06);
    @(negedge clk);
    wprot_n = 1'b0;
    fetch(8'h00);
    store(8'h0c);
    fetch(8'h00);
    @(negedge clk);
    wprot_n = 1'b1;
    cmd(8'h06);
    wr(9'h000, 1, 1);
    @(negedge clk);
    wprot_n = 1'b0;
    fetch(8'h01);
    settle();
    @(negedge clk);
    wprot_n = 1'b1;
    exp_q.push_back(d[1]);
    rd(9'h000, 1);
    // store clocked past its eighth data bit is dropped
    cmd(8'h06);
    u_host.open_frame();
    u_host.bits(8'h01, 8);
    u_host.bits(8'h0c, 8);
    u_host.bits(8'h00, 1);
    u_host.close_frame();
    fetch(8'h02);
    // write cut mid byte leaves latch set and starts nothing
    cmd(8'h06);
    u_host.open_frame();
    u_host.bits(8'h02, 8);
    u_host.bits(8'h20, 8);
    u_host.bits(d[2], 4);
    u_host.close_frame();
    fetch(8'h02);
    // slow host with a hold pause inside a status fetch
    u_host.gap_ns = 400;
    u_host.open_frame();
    u_host.bits(8'h05, 8);
    u_host.pause(oe_mid);
    `CHK("oe_hold", 1'b0, oe_mid)
    exp_q.push_back(8'h02);
    u_host.bits(8'h00, 8);
    u_host.close_frame();
    u_host.gap_ns = 0;
    `CHK("queue_left", 0, exp_q.size())
    conclude();
  end
endmodule : spe_eeprom_test
